// [pcrb_cal_timer.v]
// Calibration task timer: busy from start pulse until a fixed cycle count elapses.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "pcrb_regs.vh"
module pcrb_cal_timer (
  clk,
  rst,
  start,
  done
);
  input wire clk;
  input wire rst;
  input wire start;
  output reg done;
  reg [7:0] countReg;
  reg busyReg;
  // Last count value, cut to the counter width on purpose
  localparam [31:0] CAL_LAST = `PCRB_CAL_CYCLES - 1;
  // ************************************************
  // Counter runs while busy, done pulses at the end
  // ************************************************
  always @(posedge clk) begin
    if (rst) begin
      countReg <= 8'h00;
      busyReg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busyReg) begin
        busyReg <= 1'b1;
        countReg <= 8'h00;
      end else if (busyReg) begin
        if (countReg == CAL_LAST[7:0]) begin
          busyReg <= 1'b0;
          done <= 1'b1;
        end else begin
          countReg <= countReg + 8'h01;
        end
      end
    end
  end
endmodule

// [pcrb_config_bank.v]
// Configuration bank 0x00..0x18: buffered writes, update copy, readback select.
// Assumes a serial port front end giving byte write/read strobes on 13-bit addresses.
`timescale 1ns/1ps
`include "pcrb_regs.vh"
module pcrb_config_bank (
  clk,
  rst,
  wrEn,
  rdEn,
  addr,
  wrData,
  rdData,
  rdValid,
  lsbFirst,
  softResetPulse,
  outIntegerWord,
  outModulusWord,
  outFractionWord,
  outCtrl,
  firstOutputDivider,
  prescaleDivider,
  pumpCurrent,
  pumpModeEdges,
  pumpOffsetDividers,
  antibacklashLockDet,
  oscCalCtrl,
  oscLevel,
  oscBand,
  calBusy,
  lockIn,
  testIn,
  lockPin
);
  input wire clk;
  input wire rst;
  input wire wrEn;
  input wire rdEn;
  input wire [12:0] addr;
  input wire [7:0] wrData;
  output reg [7:0] rdData;
  output reg rdValid;
  output reg lsbFirst;
  output reg softResetPulse;
  output reg [7:0] outIntegerWord;
  output reg [19:0] outModulusWord;
  output reg [19:0] outFractionWord;
  output reg [3:0] outCtrl;
  output reg [5:0] firstOutputDivider;
  output reg [2:0] prescaleDivider;
  output reg [7:0] pumpCurrent;
  output reg [7:0] pumpModeEdges;
  output reg [7:0] pumpOffsetDividers;
  output reg [7:0] antibacklashLockDet;
  output reg [7:0] oscCalCtrl;
  output reg [7:0] oscLevel;
  output reg [7:0] oscBand;
  output reg calBusy;
  input wire lockIn;
  input wire [3:0] testIn;
  output wire lockPin;

  // ************************************************
  // Address decode and reset value functions
  // ************************************************
  // Register index 0..17 for mapped addresses, 31 when unmapped
  // Shared by the write and read paths so both agree on the map
  function [4:0] regIndex;
    input [12:0] a;
    begin
      case (a)
        `PCRB_SERIAL_PORT_CONTROL: regIndex = 5'h00;
        `PCRB_READBACK_SELECT: regIndex = 5'h01;
        `PCRB_UPDATE_STROBE: regIndex = 5'h02;
        `PCRB_PUMP_CURRENT: regIndex = 5'h03;
        `PCRB_PUMP_MODE_EDGES: regIndex = 5'h04;
        `PCRB_PUMP_OFFSET_DIVIDERS: regIndex = 5'h05;
        `PCRB_ANTIBACKLASH_LOCK_DET: regIndex = 5'h06;
        `PCRB_OSC_CALIBRATION_CTRL: regIndex = 5'h07;
        `PCRB_OSC_LEVEL: regIndex = 5'h08;
        `PCRB_OSC_BAND: regIndex = 5'h09;
        `PCRB_OUT_INTEGER_WORD: regIndex = 5'h0A;
        `PCRB_OUT_MODULUS_HIGH: regIndex = 5'h0B;
        `PCRB_OUT_MODULUS_MID: regIndex = 5'h0C;
        `PCRB_OUT_MODULUS_LOW_CTRL: regIndex = 5'h0D;
        `PCRB_OUT_FRACTION_HIGH: regIndex = 5'h0E;
        `PCRB_OUT_FRACTION_MID: regIndex = 5'h0F;
        `PCRB_OUT_FRACTION_LOW_TEST: regIndex = 5'h10;
        `PCRB_OUT_DIVIDERS: regIndex = 5'h11;
        default: regIndex = 5'h1F;
      endcase
    end
  endfunction

  // Reset value by register index
  // Registers not listed here come up as zero
  function [7:0] resetValue;
    input [4:0] i;
    begin
      case (i)
        5'h00: resetValue = `PCRB_RST_SERIAL_PORT_CONTROL;
        5'h03: resetValue = `PCRB_RST_PUMP_CURRENT;
        5'h04: resetValue = `PCRB_RST_PUMP_MODE_EDGES;
        5'h07: resetValue = `PCRB_RST_OSC_CALIBRATION_CTRL;
        5'h08: resetValue = `PCRB_RST_OSC_LEVEL;
        5'h09: resetValue = `PCRB_RST_OSC_BAND;
        5'h0B: resetValue = `PCRB_RST_OUT_MODULUS_HIGH;
        5'h0E: resetValue = `PCRB_RST_OUT_FRACTION_HIGH;
        5'h10: resetValue = `PCRB_RST_OUT_FRACTION_LOW_TEST;
        default: resetValue = `PCRB_RST_ZERO;
      endcase
    end
  endfunction

  // ************************************************
  // Internal state
  // ************************************************
  // Pending values written by the host
  reg [7:0] bufReg [0:`PCRB_NUM_REGS-1];
  // Values in use by the synthesizer
  reg [7:0] actReg [0:`PCRB_NUM_REGS-1];
  reg readbackSelReg;
  reg calStartReg;
  reg devResetReg;
  wire calDone;
  wire [4:0] wrIdx;
  wire [4:0] rdIdx;
  wire updateHit;
  wire softReset;
  integer i;
  integer j;

  assign wrIdx = regIndex(addr);
  assign rdIdx = regIndex(addr);
  // Update strobe: writing one triggers, zero does nothing
  // The strobe bit is never stored, so reads of it return zero
  assign updateHit = wrEn && (wrIdx == 5'h02) && wrData[`PCRB_UPDATE_BIT];
  // Soft or device reset returns the whole bank to defaults
  // Both resets are synchronous, so the bank sees one clean reset cycle
  assign softReset = rst || devResetReg;

  // ************************************************
  // Buffer registers written by the serial host
  // ************************************************
  always @(posedge clk) begin
    if (softReset) begin
      for (i = 0; i < `PCRB_NUM_REGS; i = i + 1) begin
        bufReg[i] <= resetValue(i[4:0]);
      end
    end else begin
      // Readback select acts at once and the strobe is only a trigger,
      // so neither of them lands in the buffer
      if (wrEn && (wrIdx < 5'h12) && (wrIdx != 5'h01) && (wrIdx != 5'h02)) begin
        if (wrIdx == 5'h00) begin
          // Fixed bits 4 and 3 stay one, bits 7 and 0 stay zero
          bufReg[0] <= (wrData & 8'h66) | `PCRB_SPC_FIXED_MASK;
        end else begin
          bufReg[wrIdx] <= wrData;
        end
      end
      if (calDone) begin
        bufReg[7][`PCRB_CAL_BIT] <= 1'b0;
      end
    end
  end

  // ************************************************
  // Active registers loaded only by the update strobe
  // ************************************************
  always @(posedge clk) begin
    if (softReset) begin
      for (j = 0; j < `PCRB_NUM_REGS; j = j + 1) begin
        actReg[j] <= resetValue(j[4:0]);
      end
    end else begin
      if (updateHit) begin
        for (j = 0; j < `PCRB_NUM_REGS; j = j + 1) begin
          actReg[j] <= bufReg[j];
        end
      end
      // Clear comes last: a finished task beats a copy of a stale one
      if (calDone) begin
        actReg[7][`PCRB_CAL_BIT] <= 1'b0;
      end
    end
  end

  // ************************************************
  // Readback select and self-clearing task launches
  // ************************************************
  always @(posedge clk) begin
    if (softReset) begin
      readbackSelReg <= 1'b0;
      calStartReg <= 1'b0;
      softResetPulse <= 1'b0;
    end else begin
      if (wrEn && (wrIdx == 5'h01)) begin
        readbackSelReg <= wrData[`PCRB_READBACK_BIT];
      end
      // Calibration starts when an update makes the bit active
      calStartReg <= updateHit && bufReg[7][`PCRB_CAL_BIT];
      // A soft reset bit written high is reported for one cycle only
      softResetPulse <= wrEn && (wrIdx == 5'h00) && wrData[`PCRB_SPC_SOFT_RESET_BIT];
    end
  end

  // Device reset request, held one cycle then cleared by the reset itself
  // Requests that arrive in the reset cycle are lost; the host must wait
  always @(posedge clk) begin
    if (rst) begin
      devResetReg <= 1'b0;
    end else if (devResetReg) begin
      devResetReg <= 1'b0;
    end else begin
      devResetReg <= wrEn && (wrIdx == 5'h00) &&
        (wrData[`PCRB_SPC_SOFT_RESET_BIT] || wrData[`PCRB_SPC_DEVICE_RESET_BIT]);
    end
  end

  // ************************************************
  // Read port and registered outputs
  // ************************************************
  always @(posedge clk) begin
    if (softReset) begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
      lsbFirst <= 1'b0;
      calBusy <= 1'b0;
      outIntegerWord <= 8'h00;
      outModulusWord <= {`PCRB_RST_OUT_MODULUS_HIGH, 12'h000};
      outFractionWord <= {`PCRB_RST_OUT_FRACTION_HIGH, 12'h000};
      outCtrl <= 4'h0;
      firstOutputDivider <= 6'h20;
      prescaleDivider <= 3'h0;
      pumpCurrent <= `PCRB_RST_PUMP_CURRENT;
      pumpModeEdges <= `PCRB_RST_PUMP_MODE_EDGES;
      pumpOffsetDividers <= 8'h00;
      antibacklashLockDet <= 8'h00;
      oscCalCtrl <= `PCRB_RST_OSC_CALIBRATION_CTRL;
      oscLevel <= `PCRB_RST_OSC_LEVEL;
      oscBand <= `PCRB_RST_OSC_BAND;
    end else begin
      // Read answer stands until the next read; valid is a single pulse
      rdValid <= rdEn;
      if (rdEn) begin
        if (rdIdx == 5'h01) begin
          rdData <= {7'h00, readbackSelReg};
        end else if (rdIdx == 5'h02 || rdIdx == 5'h1F) begin
          rdData <= 8'h00;
        end else if (readbackSelReg) begin
          rdData <= bufReg[rdIdx];
        end else begin
          rdData <= actReg[rdIdx];
        end
      end
      // Every output is a registered copy, one cycle behind the active set
      lsbFirst <= actReg[0][`PCRB_SPC_LSB_FIRST_BIT];
      calBusy <= actReg[7][`PCRB_CAL_BIT];
      outIntegerWord <= actReg[10];
      outModulusWord <= {actReg[11], actReg[12], actReg[13][7:4]};
      outCtrl <= actReg[13][3:0];
      outFractionWord <= {actReg[14], actReg[15], actReg[16][7:4]};
      firstOutputDivider <= {actReg[16][0], actReg[17][7:3]};
      prescaleDivider <= actReg[17][2:0];
      pumpCurrent <= actReg[3];
      pumpModeEdges <= actReg[4];
      pumpOffsetDividers <= actReg[5];
      antibacklashLockDet <= actReg[6];
      oscCalCtrl <= actReg[7];
      oscLevel <= actReg[8];
      oscBand <= actReg[9];
    end
  end

  // ************************************************
  // Task timer and lock pin selector
  // ************************************************
  // Calibration task timer
  pcrb_cal_timer calTimer (
    .clk(clk),
    .rst(softReset),
    .start(calStartReg),
    .done(calDone)
  );

  // Lock pin redirected to a test signal when enabled
  pcrb_test_mux testMux (
    .clk(clk),
    .rst(softReset),
    .enable(actReg[16][`PCRB_TEST_EN_BIT]),
    .sel(actReg[16][`PCRB_TEST_SEL_HI:`PCRB_TEST_SEL_LO]),
    .lockIn(lockIn),
    .testIn(testIn),
    .pinOut(lockPin)
  );
endmodule

// [pcrb_config_bank_assertions.sv]
// Checker for the configuration bank ports.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "pcrb_regs.vh"
module pcrb_config_bank_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [12:0] addr,
  input wire logic [7:0] wrData,
  input wire logic rdValid,
  input wire logic lsbFirst,
  input wire logic softResetPulse,
  input wire logic [19:0] outModulusWord,
  input wire logic [19:0] outFractionWord,
  input wire logic calBusy
);
  // ***************************
  // Properties
  // ***************************
  logic [3:0] rstHist_reg;
  wire upd = wrEn && addr == `PCRB_UPDATE_STROBE && wrData[`PCRB_UPDATE_BIT];
  wire softWr = wrEn && addr == `PCRB_SERIAL_PORT_CONTROL && wrData[5];
  wire devWr = wrEn && addr == `PCRB_SERIAL_PORT_CONTROL && wrData[`PCRB_SPC_DEVICE_RESET_BIT];
  // History of hard, soft and device resets
  always @(posedge clk) rstHist_reg <= {rstHist_reg[2:0], rst | softResetPulse | devWr};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (rdEn |=> rdValid)
    else $error("read not answered");
  chk_valid_pulse: assert property (!rdEn |=> !rdValid)
    else $error("read valid without request");
  chk_cal_start: assert property ($rose(calBusy) |-> $past(upd, 2))
    else $error("calibration without update");
  chk_cal_clear: assert property ($rose(calBusy) |=> calBusy [*8] ##[1:120] !calBusy)
    else $error("calibration bit not cleared");
  chk_update_gate: assert property ((!$stable(outFractionWord) || !$stable(outModulusWord))
    |-> $past(upd, 2) || |rstHist_reg) else $error("words changed without update");
  chk_order_update: assert property ($changed(lsbFirst) |-> $past(upd, 2) || |rstHist_reg)
    else $error("bit order changed without update");
  chk_soft_start: assert property (softWr |=> softResetPulse)
    else $error("soft reset not launched");
  chk_soft_once: assert property (softResetPulse |=> !softResetPulse)
    else $error("soft reset bit stuck");
  chk_reset_defaults: assert property ($fell(rst) |-> outModulusWord == 20'h80000
    && outFractionWord == 20'h20000 && !lsbFirst && !calBusy) else $error("bad defaults");
  cover property ($rose(calBusy));
  cover property (rdEn ##1 rdValid);
  cover property ($rose(lsbFirst));
endmodule
bind pcrb_config_bank pcrb_config_bank_assertions chk (.clk, .rst, .wrEn, .rdEn, .addr,
  .wrData, .rdValid, .lsbFirst, .softResetPulse, .outModulusWord, .outFractionWord, .calBusy);

// [pcrb_host_model.sv]
// Host model: issues byte writes and reads into the configuration bank.
// Assumes the bank takes a strobe on the rising edge of clk.
`timescale 1ns/1ps
module pcrb_host_model (
  input wire logic clk,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  output logic wrEn,
  output logic rdEn,
  output logic [12:0] addr,
  output logic [7:0] wrData
);
  // ***************************
  // Byte transfer tasks
  // ***************************
  // Bus idle at time zero
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 13'h0000;
    wrData = 8'h00;
  end
  // One write strobe; released lines show inverted values
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    wrEn = 1'b1;
    addr = a;
    wrData = d;
    @(negedge clk);
    wrEn = 1'b0;
    addr = ~a;
    wrData = ~d;
  endtask
  // One read strobe; answer taken at the negedge that releases it, while rdValid stands
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    rdEn = 1'b1;
    addr = a;
    @(negedge clk);
    rdEn = 1'b0;
    addr = ~a;
    v = rdValid;
    d = rdData;
  endtask
endmodule

// [pcrb_regs.vh]
// Register offsets, field positions and reset values of the configuration bank.
// Assumes 8-bit registers at byte offsets on a 13-bit serial address.
`ifndef PCRB_REGS_VH
`define PCRB_REGS_VH
`define PCRB_ADDR_W 13
`define PCRB_SERIAL_PORT_CONTROL 13'h0000
`define PCRB_READBACK_SELECT 13'h0004
`define PCRB_UPDATE_STROBE 13'h0005
`define PCRB_PUMP_CURRENT 13'h000A
`define PCRB_PUMP_MODE_EDGES 13'h000B
`define PCRB_PUMP_OFFSET_DIVIDERS 13'h000C
`define PCRB_ANTIBACKLASH_LOCK_DET 13'h000D
`define PCRB_OSC_CALIBRATION_CTRL 13'h000E
`define PCRB_OSC_LEVEL 13'h000F
`define PCRB_OSC_BAND 13'h0010
`define PCRB_OUT_INTEGER_WORD 13'h0011
`define PCRB_OUT_MODULUS_HIGH 13'h0012
`define PCRB_OUT_MODULUS_MID 13'h0013
`define PCRB_OUT_MODULUS_LOW_CTRL 13'h0014
`define PCRB_OUT_FRACTION_HIGH 13'h0015
`define PCRB_OUT_FRACTION_MID 13'h0016
`define PCRB_OUT_FRACTION_LOW_TEST 13'h0017
`define PCRB_OUT_DIVIDERS 13'h0018
`define PCRB_RST_SERIAL_PORT_CONTROL 8'h18
`define PCRB_RST_PUMP_CURRENT 8'h80
`define PCRB_RST_PUMP_MODE_EDGES 8'h30
`define PCRB_RST_OSC_CALIBRATION_CTRL 8'h70
`define PCRB_RST_OSC_LEVEL 8'h80
`define PCRB_RST_OSC_BAND 8'h80
`define PCRB_RST_OUT_MODULUS_HIGH 8'h80
`define PCRB_RST_OUT_FRACTION_HIGH 8'h20
`define PCRB_RST_OUT_FRACTION_LOW_TEST 8'h01
`define PCRB_RST_ZERO 8'h00
`define PCRB_SPC_FIXED_MASK 8'h18
`define PCRB_SPC_LSB_FIRST_BIT 6
`define PCRB_SPC_LSB_FIRST_MIRROR_BIT 1
`define PCRB_SPC_SOFT_RESET_BIT 5
`define PCRB_SPC_DEVICE_RESET_BIT 2
`define PCRB_READBACK_BIT 0
`define PCRB_UPDATE_BIT 0
`define PCRB_CAL_BIT 7
`define PCRB_TEST_EN_BIT 3
`define PCRB_TEST_SEL_HI 2
`define PCRB_TEST_SEL_LO 1
`define PCRB_NUM_REGS 18
`define PCRB_CAL_CYCLES_NS 1000
`define PCRB_CLK_NS 10
`define PCRB_CAL_CYCLES (`PCRB_CAL_CYCLES_NS / `PCRB_CLK_NS)
`endif

// [pcrb_test_mux.v]
// Lock-pin selector: passes lock status or one of four test signals.
// Assumes test inputs are synchronous to the clock.
`timescale 1ns/1ps
module pcrb_test_mux (
  clk,
  rst,
  enable,
  sel,
  lockIn,
  testIn,
  pinOut
);
  input wire clk;
  input wire rst;
  input wire enable;
  input wire [1:0] sel;
  input wire lockIn;
  input wire [3:0] testIn;
  output reg pinOut;
  // ************************************************
  // Registered pin select
  // ************************************************
  always @(posedge clk) begin
    if (rst) begin
      pinOut <= 1'b0;
    end else if (enable) begin
      pinOut <= testIn[sel];
    end else begin
      pinOut <= lockIn;
    end
  end
endmodule

// [tb.sv]
// Self-checking bench for the configuration bank.
// Assumes the host model drives the byte strobes.
`timescale 1ns/1ps
`include "pcrb_regs.vh"
module tb;
  // ***************************
  // Signals and instances
  // ***************************
  logic clk, rst, wrEn, rdEn, rdValid, lsbFirst, softResetPulse, calBusy, lockIn, lockPin;
  logic [12:0] addr;
  logic [7:0] wrData, rdData, outIntegerWord, pumpCurrent, pumpModeEdges, pumpOffsetDividers;
  logic [7:0] antibacklashLockDet, oscCalCtrl, oscLevel, oscBand;
  logic [19:0] outModulusWord, outFractionWord;
  logic [3:0] outCtrl, testIn;
  logic [5:0] firstOutputDivider;
  logic [2:0] prescaleDivider;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  // Rows: address, write byte, value after write, default
  localparam logic [36:0] ROWS [0:17] = '{
    {13'h00, 24'h425A18}, {13'h0A, 24'hA5A580}, {13'h0B, 24'h5A5A30}, {13'h0C, 24'h3C3C00},
    {13'h0D, 24'hC1C100}, {13'h0E, 24'h3F3F70}, {13'h0F, 24'h949480}, {13'h10, 24'h686880},
    {13'h11, 24'h121200}, {13'h12, 24'hABAB80}, {13'h13, 24'hCDCD00}, {13'h14, 24'hE7E700},
    {13'h15, 24'h9F9F20}, {13'h16, 24'h8E8E00}, {13'h17, 24'hD0D001}, {13'h18, 24'hF3F300},
    {13'h06, 24'h770000}, {13'h05, 24'h000000}};
  pcrb_host_model host (.clk, .rdData, .rdValid, .wrEn, .rdEn, .addr, .wrData);
  pcrb_config_bank uut (.clk, .rst, .wrEn, .rdEn, .addr, .wrData, .rdData, .rdValid, .lsbFirst,
    .softResetPulse, .outIntegerWord, .outModulusWord, .outFractionWord, .outCtrl,
    .firstOutputDivider, .prescaleDivider, .pumpCurrent, .pumpModeEdges, .pumpOffsetDividers,
    .antibacklashLockDet, .oscCalCtrl, .oscLevel, .oscBand, .calBusy, .lockIn, .testIn, .lockPin);
  // ***************************
  // Tasks
  // ***************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    check({v, d}, {1'b1, e}, "read");
  endtask
  // Mode 0 reads defaults, 1 writes, 2 reads written values
  task automatic sweep(input int m);
    for (int i = 0; i < 18; i++) begin
      if (m == 1) host.wr(ROWS[i][36:24], ROWS[i][23:16]);
      else rdchk(ROWS[i][36:24], m == 2 ? ROWS[i][15:8] : ROWS[i][7:0]);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ***************************
  // Clock and sequence
  // ***************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    lockIn = 1'b0;
    testIn = 4'h0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    sweep(0);
    host.wr(`PCRB_READBACK_SELECT, 8'h01);
    sweep(1);
    sweep(2);
    check(outFractionWord, 20'h20000, "held");
    host.wr(`PCRB_READBACK_SELECT, 8'h00);
    sweep(0);
    host.wr(`PCRB_UPDATE_STROBE, 8'h01);
    repeat (3) @(negedge clk);
    check(outFractionWord, 20'h9F8ED, "fraction");
    check(outModulusWord, 20'hABCDE, "modulus");
    check({outCtrl, firstOutputDivider, prescaleDivider, lsbFirst}, 14'h1DE7, "ctl");
    check({outIntegerWord, pumpCurrent}, 16'h12A5, "integer");
    check({pumpModeEdges, pumpOffsetDividers}, 16'h5A3C, "pump");
    check({antibacklashLockDet, oscCalCtrl, oscLevel, oscBand}, 32'hC13F9468, "osc");
    sweep(2);
    // Every test source through the lock pin, then lock status again
    for (int s = 0; s < 4; s++) begin
      host.wr(`PCRB_OUT_FRACTION_LOW_TEST, {5'h1B, s[1:0], 1'b0});
      host.wr(`PCRB_UPDATE_STROBE, 8'h01);
      testIn = 4'h1 << s;
      repeat (4) @(negedge clk);
      check(lockPin, 1'b1, "test source");
      testIn = ~testIn;
      repeat (2) @(negedge clk);
      check(lockPin, 1'b0, "test source");
    end
    host.wr(`PCRB_OUT_FRACTION_LOW_TEST, 8'hD0);
    host.wr(`PCRB_UPDATE_STROBE, 8'h01);
    lockIn = 1'b1;
    testIn = 4'h0;
    repeat (4) @(negedge clk);
    check(lockPin, 1'b1, "lock status");
    // Calibration runs and clears its own bit
    host.wr(`PCRB_OSC_CALIBRATION_CTRL, 8'hBF);
    host.wr(`PCRB_UPDATE_STROBE, 8'h01);
    n = 0;
    while (calBusy !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (calBusy === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    // Busy spans the timer plus the clear stage in the active set and the calBusy output register
    check(n, `PCRB_CAL_CYCLES + 2, "calibration length");
    if (n == 0 || n == 300) print_verdict();
    rdchk(`PCRB_OSC_CALIBRATION_CTRL, 8'h3F);
    host.wr(`PCRB_READBACK_SELECT, 8'h01);
    rdchk(`PCRB_OSC_CALIBRATION_CTRL, 8'h3F);
    // Soft reset returns everything to defaults
    host.wr(`PCRB_SERIAL_PORT_CONTROL, 8'h20);
    check(softResetPulse, 1'b1, "soft reset pulse");
    repeat (4) @(negedge clk);
    check({lsbFirst, outFractionWord}, 21'h20000, "soft reset");
    check({pumpCurrent, oscCalCtrl, oscLevel, oscBand}, 32'h80708080, "defaults");
    sweep(0);
    // Device reset alone also restores the active set and readback select
    host.wr(`PCRB_PUMP_CURRENT, 8'h11);
    host.wr(`PCRB_UPDATE_STROBE, 8'h01);
    @(negedge clk);
    check(pumpCurrent, 8'h11, "pump current");
    host.wr(`PCRB_READBACK_SELECT, 8'h01);
    rdchk(`PCRB_READBACK_SELECT, 8'h01);
    host.wr(`PCRB_SERIAL_PORT_CONTROL, 8'h04);
    check(softResetPulse, 1'b0, "no soft pulse");
    repeat (3) @(negedge clk);
    check(pumpCurrent, 8'h80, "device reset");
    rdchk(`PCRB_READBACK_SELECT, 8'h00);
    print_verdict();
  end
endmodule
